// ==== common/spi_flags_params.svh ====
// Bit positions, reset values and timing counts of the SPI flag block
`ifndef SPI_FLAGS_PARAMS_SVH
`define SPI_FLAGS_PARAMS_SVH

// Control word bit positions on ctrl_wdata / ctrl_q
`define SPI_CTRL_EN_BIT 0
`define SPI_CTRL_MASTER_BIT 1
`define SPI_CTRL_SELECT_DISABLE_BIT_BIT 2
`define SPI_CTRL_WIDTH 3
`define SPI_CTRL_RESET 3'h0

// Byte framing
`define SPI_LAST_BIT 3'h7
`define SPI_BYTE_RESET 8'h00

// Master clock half period, time in ns and derived mclk count
`define SPI_MCLK_MHZ 200
`define SPI_SCK_HALF_NS 50
`define SPI_HALF_CYC ((`SPI_SCK_HALF_NS * `SPI_MCLK_MHZ + 999) / 1000)
`define SPI_DIV_WIDTH 8

`endif

// ==== common/spi_flags_pkg.sv ====
// Types shared by the SPI flag block
package spi_flags_pkg;

	typedef logic [7:0] byte_t;
	typedef logic [2:0] bit_idx_t;

	// Master transfer sequencer
	typedef enum logic [1:0] {
		M_IDLE,
		M_LOW,
		M_HIGH
	} master_state_t;

endpackage : spi_flags_pkg

// ==== rtl/spi_error_interrupt_flags.sv ====
// SPI error flags, transfer flag and interrupt requests with link logic
//
// Contract
// RULE1: Master mode, select disable clear: low select input sets mode fault.
// RULE2: A set mode fault raises the receiver/error interrupt request.
// RULE3: Mode fault clears serial enable and master select.
// RULE4: With select disable set, select pin level never sets mode fault.
// RULE5: Mode fault interrupt only while select disable is zero.
// RULE6: Mode fault cleared by status read then control write; re-enable after.
// RULE7: Data write during a transfer sets write collision.
// RULE8: Collision gives no interrupt; running transfer is left untouched.
// RULE9: Status access followed by data access clears write collision.
// RULE10: No overrun flag; bytes arriving while done flag set are dropped.
// RULE11: Slave mode: select rising mid-byte sets select error.
// RULE12: Select error gives no interrupt; cleared only by enable written 0.
// RULE13: Hardware sets transfer done flag at end of each transfer.
// RULE14: Transfer done flag raises transmitter interrupt request.
// RULE15: Interrupt enable input gates both interrupt requests.
// RULE16: After reset all flags clear and no request pending.
`include "spi_flags_params.svh"

module spi_error_interrupt_flags (
	// System clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// CPU access strobes, one mclk pulse each
	input wire logic status_rd,
	input wire logic ctrl_wr,
	input wire logic [`SPI_CTRL_WIDTH-1:0] ctrl_wdata,
	input wire logic data_wr,
	input wire logic data_rd,
	input wire spi_flags_pkg::byte_t data_wdata,
	input wire logic serial_irq_enable,
	// CPU visible state
	output logic [`SPI_CTRL_WIDTH-1:0] ctrl_q,
	output spi_flags_pkg::byte_t rx_data,
	output logic mode_fault_flag,
	output logic write_collision_flag,
	output logic select_error_flag,
	output logic transfer_done_flag,
	output logic irq_tx,
	output logic irq_rx_err,
	// Link pins, master side driven from mclk
	input wire logic ss_n_in,
	input wire logic miso_in,
	output logic sck_out,
	output logic sck_oe,
	output logic mosi_out,
	output logic mosi_oe,
	// Link clock and slave side pins
	input wire logic link_sck,
	input wire logic mosi_in,
	output logic miso_out,
	output logic miso_oe
);
	import spi_flags_pkg::*;

	function automatic logic tgl_event(input logic now, input logic last);
		tgl_event = now ^ last;
	endfunction : tgl_event

	localparam logic [`SPI_DIV_WIDTH-1:0] HALF_LAST =
		`SPI_DIV_WIDTH'(`SPI_HALF_CYC - 1);

	// Control and flag registers
	logic [`SPI_CTRL_WIDTH-1:0] ctrl_reg, ctrl_next;
	logic mode_fault_flag_reg, mode_fault_flag_next, mode_fault_flag_arm_reg, mode_fault_flag_arm_next;
	logic write_collision_flag_reg, write_collision_flag_next, write_collision_flag_arm_reg, write_collision_flag_arm_next;
	logic select_error_flag_reg, select_error_flag_next;
	logic done_reg, done_next, done_arm_reg, done_arm_next;
	byte_t rx_buf_reg, rx_buf_next;
	byte_t tx_data_reg;
	// Master sequencer
	master_state_t mstate_reg, mstate_next;
	logic [`SPI_DIV_WIDTH-1:0] div_reg, div_next;
	bit_idx_t mbit_reg, mbit_next;
	byte_t mshift_reg, mshift_next;
	logic sck_reg, sck_next, mosi_reg, mosi_next;
	// Slave side crossing
	logic byte_open_reg, byte_open_next;
	logic start_seen_reg, done_seen_reg, ss_last_reg;
	logic irq_tx_reg, irq_rx_reg, sck_oe_reg, miso_oe_reg;
	// Link domain
	bit_idx_t lbit_reg;
	byte_t lshift_reg, lhold_reg;
	logic start_tgl_reg, done_tgl_reg, miso_reg;

	// Synchronised pins and toggles
	logic ss_n_s, miso_s, start_tgl_s, done_tgl_s;

	sync_2ff #(.W(1), .INIT(1'h1)) u_sync_ss (
		.clk(mclk), .reset_n(reset_n), .d(ss_n_in), .q(ss_n_s)
	);
	sync_2ff #(.W(3), .INIT(3'h0)) u_sync_misc (
		.clk(mclk), .reset_n(reset_n),
		.d({miso_in, start_tgl_reg, done_tgl_reg}),
		.q({miso_s, start_tgl_s, done_tgl_s})
	);

	// Decoded control and events
	wire en = ctrl_reg[`SPI_CTRL_EN_BIT];
	wire master = ctrl_reg[`SPI_CTRL_MASTER_BIT];
	wire select_disable_bit = ctrl_reg[`SPI_CTRL_SELECT_DISABLE_BIT_BIT];
	wire slave_on = en && !master;
	wire start_ev = tgl_event(start_tgl_s, start_seen_reg);
	wire sdone_ev = tgl_event(done_tgl_s, done_seen_reg) && slave_on;
	wire ss_rise = ss_n_s && !ss_last_reg;
	wire half_end = (div_reg == HALF_LAST);
	wire mdone_ev = (mstate_reg == M_HIGH) && half_end &&
		(mbit_reg == `SPI_LAST_BIT);
	wire busy = (mstate_reg != M_IDLE) || (slave_on && byte_open_reg);
	wire fault_ev = en && master && !select_disable_bit && !ss_n_s; // see RULE1 RULE4
	wire collide = data_wr && busy; // see RULE7
	wire m_start = data_wr && !busy && en && master && !fault_ev;
	wire xfer_ev = sdone_ev || mdone_ev;
	wire data_acc = data_wr || data_rd;
	wire en_off = ctrl_wr && !ctrl_wdata[`SPI_CTRL_EN_BIT];

	// Control register: fault forces slave and disabled
	always_comb begin
		ctrl_next = ctrl_reg;
		if (ctrl_wr)
			ctrl_next = ctrl_wdata;
		if (fault_ev) begin
			ctrl_next[`SPI_CTRL_EN_BIT] = 1'h0; // see RULE3
			ctrl_next[`SPI_CTRL_MASTER_BIT] = 1'h0; // see RULE3
		end
	end

	// Mode fault: read with flag set arms, control write completes
	always_comb begin
		mode_fault_flag_next = mode_fault_flag_reg;
		mode_fault_flag_arm_next = mode_fault_flag_arm_reg;
		if (status_rd && mode_fault_flag_reg)
			mode_fault_flag_arm_next = 1'h1; // see RULE6
		if (ctrl_wr && mode_fault_flag_arm_reg) begin
			mode_fault_flag_next = 1'h0; // see RULE6
			mode_fault_flag_arm_next = 1'h0;
		end
		// Set wins over a clear in the same cycle
		if (fault_ev) begin
			mode_fault_flag_next = 1'h1; // see RULE1
			mode_fault_flag_arm_next = 1'h0;
		end
	end

	// Write collision: status access then data access clears
	always_comb begin
		write_collision_flag_next = write_collision_flag_reg;
		write_collision_flag_arm_next = write_collision_flag_arm_reg;
		if (status_rd)
			write_collision_flag_arm_next = 1'h1;
		if (data_acc && write_collision_flag_arm_reg) begin
			write_collision_flag_next = 1'h0; // see RULE9
			write_collision_flag_arm_next = 1'h0;
		end
		if (collide)
			write_collision_flag_next = 1'h1; // see RULE7
	end

	// Transfer done and select error
	always_comb begin
		done_next = done_reg;
		done_arm_next = done_arm_reg;
		select_error_flag_next = select_error_flag_reg;
		rx_buf_next = rx_buf_reg;
		if (status_rd && done_reg)
			done_arm_next = 1'h1;
		if (data_acc && done_arm_reg) begin
			done_next = 1'h0;
			done_arm_next = 1'h0;
		end
		// Only a byte landing with the flag clear is kept
		if (xfer_ev && !done_reg) begin
			rx_buf_next = sdone_ev ? lhold_reg : mshift_reg; // see RULE10
		end
		if (xfer_ev)
			done_next = 1'h1; // see RULE13
		if (slave_on && ss_rise && byte_open_reg)
			select_error_flag_next = 1'h1; // see RULE11
		else if (en_off)
			select_error_flag_next = 1'h0; // see RULE12
	end

	// Slave byte tracking, ended by done toggle or slave mode off (enable clear or master set)
	always_comb begin
		byte_open_next = byte_open_reg;
		if (start_ev)
			byte_open_next = 1'h1;
		if (tgl_event(done_tgl_s, done_seen_reg) || !slave_on)
			byte_open_next = 1'h0;
	end

	// Master sequencer; a colliding write never reaches it
	always_comb begin
		mstate_next = mstate_reg;
		div_next = div_reg + `SPI_DIV_WIDTH'(1);
		mbit_next = mbit_reg;
		mshift_next = mshift_reg;
		sck_next = sck_reg;
		mosi_next = mosi_reg;
		case (mstate_reg)
			M_IDLE: begin
				div_next = '0;
				if (m_start) begin // see RULE8
					mstate_next = M_LOW;
					mshift_next = data_wdata;
					mosi_next = data_wdata[7];
					mbit_next = '0;
				end
			end
			M_LOW: begin
				if (half_end) begin
					div_next = '0;
					sck_next = 1'h1;
					mshift_next = {mshift_reg[6:0], miso_s};
					mstate_next = M_HIGH;
				end
			end
			M_HIGH: begin
				if (half_end) begin
					div_next = '0;
					sck_next = 1'h0;
					if (mbit_reg == `SPI_LAST_BIT) begin
						mstate_next = M_IDLE;
					end else begin
						mbit_next = mbit_reg + 3'h1;
						mosi_next = mshift_reg[7];
						mstate_next = M_LOW;
					end
				end
			end
			default: begin
				mstate_next = M_IDLE;
			end
		endcase
		// Disable or fault resets the sequencer
		if (!en || fault_ev) begin
			mstate_next = M_IDLE;
			sck_next = 1'h0;
		end
	end

	// Flag and control state
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_reg <= `SPI_CTRL_RESET;
			mode_fault_flag_reg <= 1'h0; // see RULE16
			mode_fault_flag_arm_reg <= 1'h0;
			write_collision_flag_reg <= 1'h0;
			write_collision_flag_arm_reg <= 1'h0;
			select_error_flag_reg <= 1'h0;
			done_reg <= 1'h0;
			done_arm_reg <= 1'h0;
			rx_buf_reg <= `SPI_BYTE_RESET;
		end else begin
			ctrl_reg <= ctrl_next;
			mode_fault_flag_reg <= mode_fault_flag_next;
			mode_fault_flag_arm_reg <= mode_fault_flag_arm_next;
			write_collision_flag_reg <= write_collision_flag_next;
			write_collision_flag_arm_reg <= write_collision_flag_arm_next;
			select_error_flag_reg <= select_error_flag_next;
			done_reg <= done_next;
			done_arm_reg <= done_arm_next;
			rx_buf_reg <= rx_buf_next;
		end
	end

	// Sequencer and crossing state
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			mstate_reg <= M_IDLE;
			div_reg <= '0;
			mbit_reg <= '0;
			mshift_reg <= `SPI_BYTE_RESET;
			sck_reg <= 1'h0;
			mosi_reg <= 1'h0;
			byte_open_reg <= 1'h0;
			start_seen_reg <= 1'h0;
			done_seen_reg <= 1'h0;
			ss_last_reg <= 1'h1;
		end else begin
			mstate_reg <= mstate_next;
			div_reg <= div_next;
			mbit_reg <= mbit_next;
			mshift_reg <= mshift_next;
			sck_reg <= sck_next;
			mosi_reg <= mosi_next;
			byte_open_reg <= byte_open_next;
			start_seen_reg <= start_tgl_s;
			done_seen_reg <= done_tgl_s;
			ss_last_reg <= ss_n_s;
		end
	end

	// Slave transmit byte; frozen while busy so the link may read it
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			tx_data_reg <= `SPI_BYTE_RESET;
		else if (data_wr && !busy)
			tx_data_reg <= data_wdata; // see RULE8
	end

	// Registered requests and enables; collision and select error excluded
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			irq_tx_reg <= 1'h0;
			irq_rx_reg <= 1'h0;
			sck_oe_reg <= 1'h0;
			miso_oe_reg <= 1'h0;
		end else begin
			irq_tx_reg <= serial_irq_enable && done_next; // see RULE14 RULE15
			// see RULE2 RULE5 RULE15
			irq_rx_reg <= serial_irq_enable && mode_fault_flag_next &&
				!ctrl_next[`SPI_CTRL_SELECT_DISABLE_BIT_BIT];
			sck_oe_reg <= ctrl_next[`SPI_CTRL_EN_BIT] &&
				ctrl_next[`SPI_CTRL_MASTER_BIT];
			miso_oe_reg <= slave_on && !ss_n_s;
		end
	end

	// Link domain: bit counter ends with the frame's own select
	wire link_cnt_rst_n = reset_n && !ss_n_in;

	always_ff @(posedge link_sck or negedge link_cnt_rst_n) begin
		if (!link_cnt_rst_n) begin
			lbit_reg <= '0;
			lshift_reg <= `SPI_BYTE_RESET;
		end else begin
			lbit_reg <= lbit_reg + 3'h1;
			lshift_reg <= {lshift_reg[6:0], mosi_in};
		end
	end

	// Toggles live on system reset only, so a frame end makes no event
	always_ff @(posedge link_sck or negedge reset_n) begin
		if (!reset_n) begin
			start_tgl_reg <= 1'h0;
			done_tgl_reg <= 1'h0;
			lhold_reg <= `SPI_BYTE_RESET;
		end else begin
			if (lbit_reg == 3'h0)
				start_tgl_reg <= !start_tgl_reg;
			if (lbit_reg == `SPI_LAST_BIT) begin
				done_tgl_reg <= !done_tgl_reg;
				lhold_reg <= {lshift_reg[6:0], mosi_in};
			end
		end
	end

	// Slave output on falling edge; first bit of a frame reads low
	always_ff @(negedge link_sck or negedge link_cnt_rst_n) begin
		if (!link_cnt_rst_n)
			miso_reg <= 1'h0;
		else
			miso_reg <= tx_data_reg[3'h7 - lbit_reg];
	end

	// Outputs
	assign ctrl_q = ctrl_reg;
	assign rx_data = rx_buf_reg;
	assign mode_fault_flag = mode_fault_flag_reg;
	assign write_collision_flag = write_collision_flag_reg;
	assign select_error_flag = select_error_flag_reg;
	assign transfer_done_flag = done_reg;
	assign irq_tx = irq_tx_reg;
	assign irq_rx_err = irq_rx_reg;
	assign sck_out = sck_reg;
	assign sck_oe = sck_oe_reg;
	assign mosi_out = mosi_reg;
	assign mosi_oe = sck_oe_reg;
	assign miso_out = miso_reg;
	assign miso_oe = miso_oe_reg;

endmodule : spi_error_interrupt_flags

// ==== rtl/sync_2ff.sv ====
// Two flip-flop level synchroniser
module sync_2ff #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// Destination clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Asynchronous level in, synchronised level out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_reg;

	// First stage feeds only the second stage
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_reg <= INIT;
			q <= INIT;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end

endmodule : sync_2ff

// ==== tb/spi_error_interrupt_flags_tb.sv ====
// Self-checking bench for the SPI flag block
module spi_error_interrupt_flags_tb import spi_flags_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk = 1'b0;
	logic reset_n = 1'b1;
	logic status_rd = 1'b0, ctrl_wr = 1'b0, data_wr = 1'b0, data_rd = 1'b0;
	logic serial_irq_enable = 1'b1;
	logic [2:0] ctrl_wdata = 3'h0, ctrl_q;
	byte_t data_wdata = 8'h00, rx_data;
	logic mode_fault_flag, write_collision_flag, select_error_flag;
	logic transfer_done_flag, irq_tx, irq_rx_err, sck_out;
	logic sck_oe, mosi_oe, mosi_out, miso_out, miso_oe;
	byte_t mosi_cap = 8'h00, miso_cap = 8'h00;
	logic ss_n, miso, link_sck, mosi;
	int failures = 0, check_count = 0, sck_rises = 0;

	always #2.5 mclk = ~mclk;
	// Master clock edges and data as a far-end slave samples them
	always @(posedge sck_out) begin
		sck_rises++;
		mosi_cap <= {mosi_cap[6:0], mosi_out};
	end
	// Slave answer as a far-end master samples it
	always @(posedge link_sck) miso_cap <= {miso_cap[6:0], miso_out};

	spi_error_interrupt_flags u_spi_error_interrupt_flags (.mclk(mclk),
		.reset_n(reset_n), .status_rd(status_rd), .ctrl_wr(ctrl_wr),
		.ctrl_wdata(ctrl_wdata), .data_wr(data_wr), .data_rd(data_rd),
		.data_wdata(data_wdata), .serial_irq_enable(serial_irq_enable),
		.ctrl_q(ctrl_q), .rx_data(rx_data), .mode_fault_flag(mode_fault_flag),
		.write_collision_flag(write_collision_flag), .irq_tx(irq_tx),
		.select_error_flag(select_error_flag), .irq_rx_err(irq_rx_err),
		.transfer_done_flag(transfer_done_flag), .ss_n_in(ss_n),
		.miso_in(miso), .sck_out(sck_out), .sck_oe(sck_oe),
		.mosi_out(mosi_out), .mosi_oe(mosi_oe), .link_sck(link_sck),
		.mosi_in(mosi), .miso_out(miso_out), .miso_oe(miso_oe));
	spi_far_end u_spi_far_end (.ss_n(ss_n), .link_sck(link_sck),
		.mosi(mosi), .miso(miso), .sck_out(sck_out));

	// One access: strobes are {status_rd, ctrl_wr, data_wr, data_rd}
	task automatic cpu(input logic [3:0] s, input logic [2:0] c,
		input byte_t d);
		@(posedge mclk);
		{status_rd, ctrl_wr, data_wr, data_rd} <= s;
		ctrl_wdata <= c;
		data_wdata <= d;
		@(posedge mclk);
		{status_rd, ctrl_wr, data_wr, data_rd} <= 4'h0;
	endtask : cpu
	task automatic settle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : settle
	// Bounded wait, a hang shows up as failed checks
	task automatic wait_done();
		for (int i = 0; i < 400 && transfer_done_flag !== 1'b1; i++)
			@(posedge mclk);
		#1;
	endtask : wait_done
	task automatic chk(input string n, input logic [8:0] e,
		input logic [8:0] g);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic close_out();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out

	initial begin
		// A real falling edge, so link-clock flops are reset as well
		reset_n <= 1'b0;
		repeat (4) @(posedge mclk);
		reset_n <= 1'b1;
		settle(1);
		chk("idle", 9'h000, {mode_fault_flag, write_collision_flag,
			select_error_flag, transfer_done_flag, irq_tx, irq_rx_err, ctrl_q});
		$display("test reset done");
		// Master byte with a colliding write behind it
		cpu(4'h4, 3'h3, 8'h00);
		sck_rises = 0;
		cpu(4'h2, 3'h3, 8'hA5);
		cpu(4'h2, 3'h3, 8'h5A);
		wait_done();
		chk("write_collision_flag", 9'h001, write_collision_flag);
		chk("done", 9'h001, transfer_done_flag);
		chk("irq_tx", 9'h001, irq_tx);
		chk("irq_rx", 9'h000, irq_rx_err);
		chk("sck", 9'h008, sck_rises[8:0]);
		chk("mosi", 9'h0A5, mosi_cap);
		chk("oe", 9'h003, {sck_oe, mosi_oe});
		cpu(4'h8, 3'h0, 8'h00);
		cpu(4'h1, 3'h0, 8'h00);
		settle(1);
		chk("write_collision_flag clr", 9'h000, write_collision_flag);
		chk("irq_tx clr", 9'h000, irq_tx);
		// Masked request
		@(posedge mclk) serial_irq_enable <= 1'b0;
		cpu(4'h2, 3'h3, 8'h0F);
		wait_done();
		chk("masked", 9'h002, {transfer_done_flag, irq_tx});
		chk("mosi 2", 9'h00F, mosi_cap);
		cpu(4'h8, 3'h0, 8'h00);
		cpu(4'h1, 3'h0, 8'h00);
		@(posedge mclk) serial_irq_enable <= 1'b1;
		$display("test master done");
		// Select pulled low under an enabled master
		u_spi_far_end.select(1'b0);
		settle(6);
		chk("mode_fault_flag", 9'h001, mode_fault_flag);
		chk("ctrl", 9'h000, ctrl_q);
		chk("oe off", 9'h000, {sck_oe, mosi_oe});
		chk("irq_rx", 9'h001, irq_rx_err);
		u_spi_far_end.select(1'b1);
		cpu(4'h4, 3'h0, 8'h00);
		settle(1);
		chk("mode_fault_flag kept", 9'h001, mode_fault_flag);
		cpu(4'h8, 3'h0, 8'h00);
		cpu(4'h4, 3'h0, 8'h00);
		settle(1);
		chk("mode_fault_flag clr", 9'h000, {mode_fault_flag, irq_rx_err});
		cpu(4'h4, 3'h7, 8'h00);
		u_spi_far_end.select(1'b0);
		settle(6);
		chk("select_disable_bit", 9'h000, {mode_fault_flag, irq_rx_err});
		u_spi_far_end.select(1'b1);
		$display("test fault done");
		// Slave bytes, second one while done still set
		cpu(4'h4, 3'h1, 8'h00);
		cpu(4'h2, 3'h1, 8'hC6);
		u_spi_far_end.select(1'b0);
		settle(6);
		chk("miso_oe", 9'h001, miso_oe);
		u_spi_far_end.select(1'b1);
		settle(2);
		u_spi_far_end.frame(8'h3C, 8);
		settle(6);
		chk("rx1", 9'h13C, {transfer_done_flag, rx_data});
		chk("miso", 9'h046, miso_cap);
		u_spi_far_end.frame(8'hC3, 8);
		settle(6);
		chk("rx drop", 9'h13C, {transfer_done_flag, rx_data});
		cpu(4'h8, 3'h0, 8'h00);
		cpu(4'h1, 3'h0, 8'h00);
		u_spi_far_end.frame(8'h5A, 8);
		settle(6);
		chk("rx2", 9'h05A, rx_data);
		cpu(4'h8, 3'h0, 8'h00);
		cpu(4'h1, 3'h0, 8'h00);
		// Select released after five bits
		u_spi_far_end.frame(8'hFF, 5);
		settle(6);
		chk("select_error_flag", 9'h002, {select_error_flag, irq_rx_err});
		cpu(4'h4, 3'h1, 8'h00);
		settle(1);
		chk("select_error_flag kept", 9'h001, select_error_flag);
		cpu(4'h4, 3'h0, 8'h00);
		settle(1);
		chk("select_error_flag clr", 9'h000, select_error_flag);
		$display("test slave done");
		close_out();
	end

	// Whole run is a few microseconds; this only cuts a hang
	initial begin
		#100us;
		failures++;
		close_out();
	end
endmodule : spi_error_interrupt_flags_tb

// ==== tb/spi_far_end.sv ====
// Behavioural far end: link master frames, and a slave answering the master
module spi_far_end import spi_flags_pkg::*; (
	// Link lines driven by the far end
	output logic ss_n = 1'b1,
	output logic link_sck = 1'b0,
	output logic mosi = 1'b0,
	output logic miso = 1'b0,
	// Master clock from the block
	input wire logic sck_out
);
	timeunit 1ns;
	timeprecision 100ps;
	// Slave answer changes every bit so stale data never matches
	always @(negedge sck_out) miso <= ~miso;
	// Select level, off the mclk grid
	task automatic select(input logic lvl);
		#7;
		ss_n = lvl;
	endtask : select
	// Mode 0 frame, MSB first; clock stands still outside it
	task automatic frame(input byte_t b, input int n);
		#7;
		ss_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			mosi = b[7-i];
			#15 link_sck = 1'b1;
			#15 link_sck = 1'b0;
		end
		#15 ss_n = 1'b1;
		mosi = ~mosi;
	endtask : frame
endmodule : spi_far_end

// ==== tb/spi_flags_chk.sv ====
// Port assertions for the SPI flag block
`include "spi_flags_params.svh"
module spi_flags_chk (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// CPU side
	input wire logic ctrl_wr,
	input wire logic [`SPI_CTRL_WIDTH-1:0] ctrl_wdata,
	input wire logic data_wr,
	input wire logic serial_irq_enable,
	// Flags and requests
	input wire logic [`SPI_CTRL_WIDTH-1:0] ctrl_q,
	input wire logic mode_fault_flag,
	input wire logic write_collision_flag,
	input wire logic select_error_flag,
	input wire logic transfer_done_flag,
	input wire logic irq_tx,
	input wire logic irq_rx_err
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int EN = `SPI_CTRL_EN_BIT;
	localparam int MS = `SPI_CTRL_MASTER_BIT;
	localparam int SD = `SPI_CTRL_SELECT_DISABLE_BIT_BIT;
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// Requests follow the flags, enable sampled at the same edge
	rx_gate_a: assert property (irq_rx_err == (mode_fault_flag &&
		!ctrl_q[SD] && $past(serial_irq_enable))) else $error("rx request bad");
	tx_gate_a: assert property (irq_tx == (transfer_done_flag &&
		$past(serial_irq_enable))) else $error("tx request bad");
	// Mode fault only from an enabled master with select in use
	mf_cause_a: assert property ($rose(mode_fault_flag) |->
		$past(ctrl_q[EN] && ctrl_q[MS] && !ctrl_q[SD])) else $error("fault cause");
	mf_off_a: assert property ($rose(mode_fault_flag) |->
		!ctrl_q[EN] && !ctrl_q[MS]) else $error("fault left enable");
	select_disable_bit_block_a: assert property (ctrl_q[SD] && !mode_fault_flag |=>
		!mode_fault_flag) else $error("fault with select off");
	mf_clear_a: assert property ($fell(mode_fault_flag) |->
		$past(ctrl_wr)) else $error("fault cleared without write");
	write_collision_flag_cause_a: assert property ($rose(write_collision_flag) |->
		$past(data_wr)) else $error("collision without data write");
	// Select error is sticky until enable is written low
	select_error_flag_keep_a: assert property (select_error_flag &&
		!(ctrl_wr && !ctrl_wdata[EN]) |=> select_error_flag) else $error("select_error_flag lost");
	select_error_flag_clr_a: assert property (ctrl_wr && !ctrl_wdata[EN] |=>
		!select_error_flag) else $error("select_error_flag kept");
	c_fault: cover property ($rose(mode_fault_flag));
	c_done: cover property ($rose(transfer_done_flag));
	c_select_error_flag: cover property ($rose(select_error_flag));
	c_write_collision_flag: cover property ($rose(write_collision_flag));
endmodule : spi_flags_chk

bind spi_error_interrupt_flags spi_flags_chk u_spi_flags_chk (.mclk(mclk),
	.reset_n(reset_n), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
	.data_wr(data_wr), .serial_irq_enable(serial_irq_enable), .ctrl_q(ctrl_q),
	.mode_fault_flag(mode_fault_flag), .irq_tx(irq_tx),
	.write_collision_flag(write_collision_flag), .irq_rx_err(irq_rx_err),
	.select_error_flag(select_error_flag),
	.transfer_done_flag(transfer_done_flag));
